// [common/sim_regs_pkg.sv]
// package: offsets, field positions and types for the reset/break status registers
package sim_regs_pkg;

    // register byte addresses (word aligned)
    localparam logic [3:0] ADDR_BREAK_EXIT = 4'h0;
    localparam logic [3:0] ADDR_RESET_SRC = 4'h4;
    localparam logic [3:0] ADDR_BREAK_CLR = 4'h8;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'hc;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;
    localparam logic [4:0] ADDR_IRQ_MASK_HI = 5'h10;

    // break_exit_status fields
    localparam int BREAK_EXIT_BIT = 1;
    // reset_source_status fields
    localparam int LOW_VOLTAGE_BIT = 1;
    localparam int BAD_ADDRESS_BIT = 3;
    localparam int BAD_OPCODE_BIT = 4;
    localparam int WATCHDOG_BIT = 5;
    localparam int EXT_PIN_BIT = 6;
    localparam int POWER_ON_BIT = 7;
    // break_flag_clear_control fields
    localparam int BREAK_CLEAR_EN_BIT = 7;
    // interrupt status fields
    localparam int IRQ_RESET_BIT = 0;
    localparam int IRQ_BREAK_EXIT_BIT = 1;

    // reset values
    localparam logic [7:0] BREAK_EXIT_RST = 8'h00;
    localparam logic [7:0] BREAK_CLR_RST = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] RESET_SRC_POR = 8'h80;

    // reset-source event strobes from the reset logic
    typedef struct packed {
        logic power_on;
        logic ext_pin;
        logic watchdog;
        logic bad_opcode;
        logic bad_address;
        logic low_voltage;
    } reset_src_t;

    // classic wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [4:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    // whole module state
    typedef struct packed {
        logic [31:0] dat;
        logic ack;
        logic [7:0] break_exit;
        logic [7:0] reset_src;
        logic [7:0] break_clr;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic irq;
        logic clear_allow;
    } sim_state_t;

endpackage

// [hw/sim_reset_break_status_regs.sv]
// reset-source, break-exit and break flag-clear registers on a wishbone slave
// Function
// - five block registers: break exit, reset source, break clear control, interrupt status, interrupt mask
// - break exit flag set when break ends stop or wait, else stays zero
// - break exit flag cleared by writing zero to it, and by system reset rst_i; reset-source events leave it
// - reset source register is read-only; writes never change its flags
// - power-on reset sets power-on flag and clears all other source flags
// - other resets set only their own flag, flags accumulate
// - any read of reset source register clears all flags after the read
// - only a read or a power-on reset clears reset flags; multiple sources all stay set
// - power-on flag is one since power-on until a read
// - external pin flag is one after pin reset until power-on or read
// - watchdog flag is one after watchdog reset until power-on or read
// - bad opcode flag is one after that reset until power-on or read
// - bad address flag is one after that reset until power-on or read
// - low-voltage flag is one after that reset until power-on or read
// - clear enable bit read/write; when one, clears allowed in break state
// - clear enable zero blocks clearing of other modules' flags in break
// - a flag cleared in break with enable stays cleared after break
// - blocked two-step clears stay protected; second step after break clears
`timescale 1ns/10ps

module sim_reset_break_status_regs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // reset source event strobes, one cycle each
    input wire sim_regs_pkg::reset_src_t reset_src_i,
    // break and low-power state
    input wire logic break_exit_lp_i,
    input wire logic break_state_i,
    // gate for status clearing in other modules
    output logic clear_allow_o,
    // interrupt
    output logic irq_o
);

    sim_regs_pkg::sim_state_t st_ff;
    sim_regs_pkg::sim_state_t nxt_st;

    logic req;
    logic wr;
    logic rd;
    logic lane0;
    logic [7:0] wbyte;
    logic [7:0] rdata;
    logic hit_exit;
    logic hit_src;
    logic hit_clr;
    logic hit_ists;
    logic hit_imsk;
    logic any_reset_ev;

    // bus decode; an access is taken only in the cycle before ack
    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign lane0 = wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign any_reset_ev = |reset_src_i;

    // address decode, unmapped reads return zero and writes are dropped
    always_comb begin
        hit_exit = 1'b0;
        hit_src = 1'b0;
        hit_clr = 1'b0;
        hit_ists = 1'b0;
        hit_imsk = 1'b0;
        if (wb_adr_i == {1'b0, sim_regs_pkg::ADDR_BREAK_EXIT}) begin
            hit_exit = 1'b1;
        end else if (wb_adr_i == {1'b0, sim_regs_pkg::ADDR_RESET_SRC}) begin
            hit_src = 1'b1;
        end else if (wb_adr_i == {1'b0, sim_regs_pkg::ADDR_BREAK_CLR}) begin
            hit_clr = 1'b1;
        end else if (wb_adr_i == {1'b0, sim_regs_pkg::ADDR_IRQ_STATUS}) begin
            hit_ists = 1'b1;
        end else if (wb_adr_i == sim_regs_pkg::ADDR_IRQ_MASK_HI) begin
            hit_imsk = 1'b1;
        end
    end

    // read mux; only the low byte carries data, upper bits zero
    always_comb begin
        rdata = 8'h00;
        if (hit_exit) begin
            rdata = st_ff.break_exit;
        end else if (hit_src) begin
            rdata = st_ff.reset_src;
        end else if (hit_clr) begin
            rdata = st_ff.break_clr;
        end else if (hit_ists) begin
            rdata = st_ff.irq_status;
        end else if (hit_imsk) begin
            rdata = st_ff.irq_mask;
        end
    end

    // next-state logic for the whole block
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        nxt_st.dat = rd ? {24'h000000, rdata} : 32'h00000000;

        // break exit flag: software may only write zero; set wins over clear
        if (wr && lane0 && hit_exit && !wbyte[sim_regs_pkg::BREAK_EXIT_BIT]) begin
            nxt_st.break_exit[sim_regs_pkg::BREAK_EXIT_BIT] = 1'b0;
        end
        if (break_exit_lp_i) begin
            nxt_st.break_exit[sim_regs_pkg::BREAK_EXIT_BIT] = 1'b1;
        end

        // reset source flags: a completed read clears, writes ignored
        if (rd && hit_src) begin
            nxt_st.reset_src = 8'h00;
        end
        // events after the read clear so a coincident reset is not lost
        if (reset_src_i.power_on) begin
            nxt_st.reset_src = sim_regs_pkg::RESET_SRC_POR;
        end else begin
            // other sources only add their own bit
            if (reset_src_i.ext_pin) begin
                nxt_st.reset_src[sim_regs_pkg::EXT_PIN_BIT] = 1'b1;
            end
            if (reset_src_i.watchdog) begin
                nxt_st.reset_src[sim_regs_pkg::WATCHDOG_BIT] = 1'b1;
            end
            if (reset_src_i.bad_opcode) begin
                nxt_st.reset_src[sim_regs_pkg::BAD_OPCODE_BIT] = 1'b1;
            end
            if (reset_src_i.bad_address) begin
                nxt_st.reset_src[sim_regs_pkg::BAD_ADDRESS_BIT] = 1'b1;
            end
            if (reset_src_i.low_voltage) begin
                nxt_st.reset_src[sim_regs_pkg::LOW_VOLTAGE_BIT] = 1'b1;
            end
        end

        // break clear enable, only its one bit is stored
        if (wr && lane0 && hit_clr) begin
            nxt_st.break_clr = 8'h00;
            nxt_st.break_clr[sim_regs_pkg::BREAK_CLEAR_EN_BIT] =
                wbyte[sim_regs_pkg::BREAK_CLEAR_EN_BIT];
        end

        // interrupt mask, two defined bits
        if (wr && lane0 && hit_imsk) begin
            nxt_st.irq_mask = wbyte & 8'h03;
        end

        // interrupt status: write one to clear, events win
        if (wr && lane0 && hit_ists) begin
            nxt_st.irq_status = st_ff.irq_status & ~wbyte;
        end
        if (any_reset_ev) begin
            nxt_st.irq_status[sim_regs_pkg::IRQ_RESET_BIT] = 1'b1;
        end
        if (break_exit_lp_i) begin
            nxt_st.irq_status[sim_regs_pkg::IRQ_BREAK_EXIT_BIT] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);

        // outside break clearing is free; in break only with enable set.
        // other modules hold their two-step sequence while this is low,
        // so a first step before break never completes inside it
        nxt_st.clear_allow = !break_state_i ||
            nxt_st.break_clr[sim_regs_pkg::BREAK_CLEAR_EN_BIT];
    end

    // state register; system reset keeps reset flags, they record the cause
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff.dat <= 32'h00000000;
            st_ff.ack <= 1'b0;
            st_ff.break_exit <= sim_regs_pkg::BREAK_EXIT_RST;
            st_ff.reset_src <= nxt_st.reset_src;
            st_ff.break_clr <= sim_regs_pkg::BREAK_CLR_RST;
            st_ff.irq_status <= sim_regs_pkg::IRQ_STATUS_RST;
            st_ff.irq_mask <= sim_regs_pkg::IRQ_MASK_RST;
            st_ff.irq <= 1'b0;
            st_ff.clear_allow <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign irq_o = st_ff.irq;
    assign clear_allow_o = st_ff.clear_allow;

endmodule

// [testbench/sim_regs_checker.sv]
// assertion checker for the reset/break status register block
`timescale 1ns/10ps
module sim_regs_checker (
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // events and gate
    input wire sim_regs_pkg::reset_src_t reset_src_i,
    input wire logic break_exit_lp_i,
    input wire logic break_state_i,
    input wire logic clear_allow_o
);
    // events placed on their status bit positions
    wire logic [7:0] ev_m = {reset_src_i.power_on, reset_src_i.ext_pin, reset_src_i.watchdog,
        reset_src_i.bad_opcode, reset_src_i.bad_address, 1'b0, reset_src_i.low_voltage, 1'b0};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a read taken with no event racing it
    sequence rd_at(a);
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a && ev_m == 8'h00;
    endsequence
    sequence quiet_gap;
        ev_m == 8'h00 && !break_exit_lp_i;
    endsequence
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
    chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper bits set");
    chk_clear_gate: assert property (!break_state_i |=> clear_allow_o)
        else $error("gate closed outside break");
    chk_read_clears: assert property (rd_at(5'h04) ##1 (wb_ack_o && ev_m == 8'h00)
        ##1 (ev_m == 8'h00 && !break_exit_lp_i && !wb_cyc_i) ##1 rd_at(5'h04)
        |=> wb_dat_o == 32'h0)
        else $error("flags survive read");
    chk_por_flags: assert property (ev_m == 8'h80 ##1 quiet_gap ##1 rd_at(5'h04)
        |=> wb_dat_o == 32'h80) else $error("power-on flags");
    chk_src_accum: assert property ((ev_m != 8'h00 && !ev_m[7]) ##1 quiet_gap
        ##1 rd_at(5'h04) |=> (wb_dat_o[7:0] & $past(ev_m, 3)) == $past(ev_m, 3))
        else $error("source flag lost");
    chk_break_flag: assert property (break_exit_lp_i ##1 quiet_gap ##1 rd_at(5'h00)
        |=> wb_dat_o[1]) else $error("break flag");
endmodule
bind sim_reset_break_status_regs sim_regs_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_src_i(reset_src_i),
    .break_exit_lp_i(break_exit_lp_i), .break_state_i(break_state_i),
    .clear_allow_o(clear_allow_o));

// [testbench/src_model.sv]
// model of the reset sources and break logic feeding the block
`timescale 1ns/10ps
module src_model (
    // clock
    input wire logic clk_i,
    // event strobes and break level
    output sim_regs_pkg::reset_src_t reset_src_o,
    output logic break_exit_o,
    output logic break_state_o
);
    // quiet until commanded
    initial begin
        reset_src_o = 6'h00;
        break_exit_o = 1'b0;
        break_state_o = 1'b0;
    end
    // strobes last exactly one cycle, as the block expects
    task automatic fire(input sim_regs_pkg::reset_src_t ev, input logic brk);
        @(posedge clk_i);
        {reset_src_o, break_exit_o} <= {ev, brk};
        @(posedge clk_i);
        {reset_src_o, break_exit_o} <= 7'h00;
    endtask
    task automatic set_break(input logic b);
        @(posedge clk_i);
        break_state_o <= b;
    endtask
endmodule

// [testbench/testbench.sv]
// self-checking bench for the reset/break status register block
`timescale 1ns/10ps
module testbench;
    logic clk_i, rst_i, cyc, stb, we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, clear_allow_o, irq_o, brk_exit, brk_state;
    wire sim_regs_pkg::reset_src_t rsrc;
    int errors, checked, cycles;
    sim_reset_break_status_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_src_i(rsrc),
        .break_exit_lp_i(brk_exit), .break_state_i(brk_state),
        .clear_allow_o(clear_allow_o), .irq_o(irq_o));
    src_model src_u (.clk_i(clk_i), .reset_src_o(rsrc), .break_exit_o(brk_exit),
        .break_state_o(brk_state));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // classic cycle; ack sampled at the falling edge, bounded wait
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, 24'h0, d};
        // ack is looked at mid-cycle, so the edge that launches it is no race
        do begin
            @(negedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1)
            errors++;
        rdat = wb_dat_o;
        // release only after the rising edge at which ack stands high
        @(posedge clk_i);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        wb(1'b0, a, 8'h00, 4'hf);
        check(rdat, e);
    endtask
    task automatic t_src;
        rd(5'h04, 32'h80);
        rd(5'h04, 32'h00);
        for (int i = 0; i < 5; i++)
            src_u.fire(6'h01 << i, 1'b0);
        wr(5'h04, 8'h00);
        rd(5'h04, 32'h7a);
        src_u.fire(6'h10, 1'b0);
        rd(5'h04, 32'h40);
        src_u.fire(6'h10, 1'b0);
        src_u.fire(6'h20, 1'b0);
        rd(5'h04, 32'h80);
        rd(5'h14, 32'h00);
    endtask
    task automatic t_break;
        src_u.fire(6'h00, 1'b1);
        rd(5'h00, 32'h02);
        wr(5'h00, 8'h02);
        rd(5'h00, 32'h02);
        wr(5'h00, 8'h00);
        rd(5'h00, 32'h00);
        src_u.fire(6'h00, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(5'h00, 32'h00);
    endtask
    // the gate: enable write, then break with and without enable
    task automatic t_gate;
        wb(1'b1, 5'h08, 8'h80, 4'h0);
        rd(5'h08, 32'h00);
        wr(5'h08, 8'h80);
        rd(5'h08, 32'h80);
        src_u.set_break(1'b1);
        repeat (3) @(posedge clk_i);
        check({31'h0, clear_allow_o}, 32'h1);
        wr(5'h08, 8'h00);
        repeat (3) @(posedge clk_i);
        check({31'h0, clear_allow_o}, 32'h0);
        src_u.set_break(1'b0);
        repeat (3) @(posedge clk_i);
        check({31'h0, clear_allow_o}, 32'h1);
    endtask
    // interrupt: raise, mask, clear
    task automatic t_irq;
        wr(5'h0c, 8'h03);
        wr(5'h10, 8'h01);
        src_u.fire(6'h08, 1'b0);
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        wr(5'h10, 8'h00);
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(5'h0c, 32'h01);
        wr(5'h0c, 8'h01);
        wr(5'h10, 8'h01);
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
    endtask
    // guard against a hung handshake
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            errors++;
            end_of_test();
        end
    end
    // power-on strobe lands inside the two reset cycles
    initial begin
        {rst_i, cyc, stb, we, adr, sel, wdat} = {1'b1, 44'h0};
        src_u.fire(6'h20, 1'b0);
        rst_i <= 1'b0;
        t_src();
        t_break();
        t_gate();
        t_irq();
        end_of_test();
    end
endmodule
